//--- rtl/pfs_pkg.sv
// Purpose: Shared constants for the program flow sequencer pair.
// Assumes: One system clock, synchronous active-high reset.
// Notes:   Opcode codes are arbitrary apart from the two no-op patterns.
package pfs_pkg;
   localparam int          PC_WIDTH      = 12;
   localparam int          STACK_DEPTH   = 16;
   localparam int          OP_WIDTH      = 4;
   localparam int          IO_WIDTH      = 8;
   localparam logic [3:0]  OP_NOP0       = 4'h0;
   localparam logic [3:0]  OP_LOAD       = 4'h1;
   localparam logic [3:0]  OP_SKIP_ZERO  = 4'hE;
   localparam logic [3:0]  OP_JUMP       = 4'hC;
   localparam logic [3:0]  OP_RETURN     = 4'hD;
   localparam logic [3:0]  OP_STORE      = 4'h8;
   localparam logic [3:0]  OP_NOPF       = 4'hF;
   localparam logic [11:0] PC_RESET      = 12'h000;
   localparam logic [11:0] FEATURE_BASE  = 12'h800;
   localparam logic [11:0] FEATURE_LIMIT = 12'h8FF;
endpackage

//--- rtl/pfs_link_if.sv
`timescale 1ns/1ps
// Purpose: Link between control processor and program flow sequencer.
// Assumes: Single clock; all signals synchronous.
// Notes:   No tristate wires; pulses last one clock cycle per executed word.
interface pfs_link_if;
   import pfs_pkg::*;
   logic                jump_pulse;
   logic                return_pulse;
   logic                nop0_pulse;
   logic                nopf_pulse;
   logic                write_strobe;
   logic [OP_WIDTH-1:0] opcode;
   logic [IO_WIDTH-1:0] operand;
   logic                phase;
   modport proc (
      output jump_pulse, return_pulse, nop0_pulse, nopf_pulse,
      output write_strobe, phase,
      input  opcode, operand
   );
   modport seq (
      input  jump_pulse, return_pulse, nop0_pulse, nopf_pulse,
      input  write_strobe, phase,
      output opcode, operand
   );
endinterface

//--- rtl/pfs_control_processor.sv
`timescale 1ns/1ps
// Purpose: One-bit control processor end: decodes opcodes, emits pulses.
// Assumes: Sequencer presents opcode and operand every cycle.
// Notes:   Pulses are decoded from the word being executed, so the
//          counter loads at the end of that same instruction cycle;
//          phase stands low as a clock stand-in for every pulse except one in the first cycle after reset.
module pfs_control_processor
   import pfs_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   pfs_link_if.proc                 link,
   input  wire logic                i_data,
   output logic                     o_data,
   output logic                     o_result
);
   logic                result_reg;
   logic                ignore_reg;
   logic                out_reg;
   logic                phase_reg;
   logic                live;
   logic [OP_WIDTH-1:0] op;

   assign op   = link.opcode;
   // No pulse may leak out while reset holds the counter
   assign live = !ignore_reg && !i_sys_rst;

   // ==========================================================
   // Phase: high in reset and the first cycle after it, low through every later instruction cycle
   // pulses can begin before phase falls, in the first cycle after reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         phase_reg <= 1'b1;
      end else begin
         phase_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Result register and skip state
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         result_reg <= 1'b0;
      end else if (live && op == OP_LOAD) begin
         result_reg <= i_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ignore_reg <= 1'b0;
      end else begin
         // Return re-fetches the call word, which must not run again
         ignore_reg <= live && ((op == OP_SKIP_ZERO && !result_reg) ||
                                op == OP_RETURN);
      end
   end

   // ==========================================================
   // Control pulses, at most one per executed word
   // jump pulse one cycle
   assign link.jump_pulse   = live && op == OP_JUMP;
   assign link.return_pulse = live && op == OP_RETURN;
   assign link.nop0_pulse   = live && op == OP_NOP0;
   assign link.nopf_pulse   = live && op == OP_NOPF;
   assign link.write_strobe = live && op == OP_STORE;
   assign link.phase        = phase_reg;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         out_reg <= 1'b0;
      end else if (live && op == OP_STORE) begin
         out_reg <= result_reg;
      end
   end

   assign o_data            = out_reg;
   assign o_result          = result_reg;
endmodule

//--- rtl/pfs_sequencer.sv
`timescale 1ns/1ps
// Purpose: Program counter, return stack, ROM fetch and I/O decode.
// Assumes: Processor pulses last one cycle per word; ROM read is combinational.
// Notes:   Call strobe is the all-ones no-op pulse; the all-zero one
//          is left free. Jump target is the operand of that word.
module pfs_sequencer
   import pfs_pkg::*;
#(
   parameter int DEPTH       = STACK_DEPTH,
   parameter int AW          = PC_WIDTH,
   parameter bit INTERLEAVED = 1'b0
)(
   input  wire logic                       i_clk,
   input  wire logic                       i_sys_rst,
   pfs_link_if.seq                         link,
   input  wire logic                       i_feature_present,
   input  wire logic [OP_WIDTH+IO_WIDTH-1:0] i_main_rom_data,
   input  wire logic [OP_WIDTH+IO_WIDTH-1:0] i_feat_rom_data,
   output logic [AW:0]                     o_rom_addr,
   output logic                            o_main_rom_en,
   output logic                            o_feat_rom_en,
   output logic [15:0]                     o_in_select,
   output logic [15:0]                     o_out_select,
   output logic [AW-1:0]                   o_pc
);
   logic [AW-1:0] pc_reg;
   logic [AW-1:0] pc_next;
   logic [AW-1:0] stack_mem [DEPTH-1];
   logic [OP_WIDTH+IO_WIDTH-1:0] word;
   logic [AW-1:0] target;
   logic feat_win;

   // ==========================================================
   // ROM enables and fetch
   // feature window decode
   assign feat_win      = pc_reg >= FEATURE_BASE[AW-1:0] &&
                          pc_reg <= FEATURE_LIMIT[AW-1:0];
   assign o_feat_rom_en = feat_win;
   assign o_main_rom_en = !feat_win;
   assign o_rom_addr    = INTERLEAVED ? {pc_reg, link.phase}
                                      : {1'b0, pc_reg};
   // absent card reads all zeros; all ones
   // would raise the call strobe and throw the counter off
   always_comb begin
      if (!feat_win) begin
         word = i_main_rom_data;
      end else if (i_feature_present) begin
         word = i_feat_rom_data;
      end else begin
         word = '0;
      end
   end
   assign link.opcode  = word[OP_WIDTH+IO_WIDTH-1:IO_WIDTH];
   assign link.operand = word[IO_WIDTH-1:0];
   assign target       = AW'(word[IO_WIDTH-1:0]);

   // ==========================================================
   // Counter next value
   always_comb begin
      pc_next = pc_reg + 1'b1;
      if (link.jump_pulse || link.nopf_pulse) begin
         pc_next = target;
      end else if (link.return_pulse) begin
         pc_next = stack_mem[0];
      end
   end

   // top entry is the address counter
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pc_reg <= PC_RESET[AW-1:0];
      end else begin
         pc_reg <= pc_next;
      end
   end

   // ==========================================================
   // saved entries below the top
   // Top entry is pc_reg, so DEPTH-1 words sit below it
   genvar g;
   generate
      for (g = 0; g < DEPTH-1; g++) begin : g_stack
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               stack_mem[g] <= '0;
            end else if (link.nopf_pulse) begin
               stack_mem[g] <= (g == 0) ? pc_reg
                                        : stack_mem[(g == 0) ? 0 : g-1];
            end else if (link.return_pulse) begin
               stack_mem[g] <= (g == DEPTH-2) ? '0
                               : stack_mem[(g == DEPTH-2) ? g : g+1];
            end
         end
      end
   endgenerate

   // ==========================================================
   // I/O decode
   // write strobe splits in/out
   always_comb begin
      o_in_select  = '0;
      o_out_select = '0;
      if (link.write_strobe) begin
         o_out_select[link.operand[3:0]] = 1'b1;
      end else begin
         o_in_select[link.operand[3:0]] = 1'b1;
      end
   end

   assign o_pc = pc_reg;
endmodule

//--- test/pfs_link_chk.sv
// Purpose: Checks the pulses on the processor to sequencer link.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees link signals only; no sequencer internals.
`timescale 1ns/1ps
module pfs_link_chk
   import pfs_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   input  wire logic                jump_pulse,
   input  wire logic                return_pulse,
   input  wire logic                nop0_pulse,
   input  wire logic                nopf_pulse,
   input  wire logic                phase,
   input  wire logic [OP_WIDTH-1:0] opcode
);
   // ==========================================================
   // Pulse relations
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_jump_single: assert property (
      jump_pulse |=> !jump_pulse) else $error("jump pulse too long");
   a_jump_cause: assert property (
      jump_pulse |-> opcode == OP_JUMP) else $error("stray jump");
   a_jump_phase: assert property (
      jump_pulse |-> !phase) else $error("jump pulse off phase");
   a_ret_single: assert property (
      return_pulse |=> !return_pulse) else $error("return too long");
   a_ret_cause: assert property (
      return_pulse |-> opcode == OP_RETURN) else $error("stray return");
   a_ret_quiet: assert property (
      return_pulse |=> !(jump_pulse || nop0_pulse || nopf_pulse))
      else $error("word after return acted on");
   a_nopf_cause: assert property (
      nopf_pulse |-> opcode == OP_NOPF) else $error("stray call");
   a_nop0_cause: assert property (
      nop0_pulse |-> opcode == OP_NOP0) else $error("stray nop0");
   a_pulse_alone: assert property (
      $onehot0({jump_pulse, return_pulse, nop0_pulse, nopf_pulse}))
      else $error("two pulses at once");
endmodule

//--- test/program_flow_sequencer_bench.sv
// Purpose: Runs the processor and sequencer pair on a small program.
// Assumes: Wide ROM; input bit low except in the no-skip run.
// Notes:   Subroutine at 030 is reached only through the call.
`timescale 1ns/1ps
module program_flow_sequencer_bench;
   import pfs_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        present = 1'b0;
   logic [11:0] main_word;
   logic [12:0] rom_addr;
   logic [11:0] pc;
   logic        main_en, feat_en;
   logic        din = 1'b0;
   logic        result, out_bit;
   logic [15:0] in_sel, out_sel;
   int          failures = 0, compares = 0, k;
   int          n_jump = 0, n_ret = 0, n_call = 0, n_nop = 0, n_wr = 0;
   int          s_jump, s_ret, s_call, s_nop, s_wr;
   pfs_link_if link ();
   always #2.5 i_clk = ~i_clk;
   // ==========================================================
   // Program ROM and pulse counters
   always_comb begin
      case (pc)
         12'h000: main_word = {OP_LOAD, 8'h00};
         12'h001: main_word = {OP_SKIP_ZERO, 8'h00};
         12'h002: main_word = {OP_JUMP, 8'hF0};
         12'h003: main_word = {OP_NOPF, 8'h30};
         12'h004: main_word = {OP_JUMP, 8'h40};
         12'h030: main_word = {OP_STORE, 8'h01};
         12'h031: main_word = {OP_RETURN, 8'h00};
         12'h0F0: main_word = {OP_STORE, 8'h02};
         default: main_word = 12'h000;
      endcase
   end
   always @(posedge i_clk) begin
      n_jump <= n_jump + (link.jump_pulse === 1'b1);
      n_ret <= n_ret + (link.return_pulse === 1'b1);
      n_call <= n_call + (link.nopf_pulse === 1'b1);
      n_nop <= n_nop + (link.nop0_pulse === 1'b1);
      n_wr <= n_wr + (link.write_strobe === 1'b1);
   end
   pfs_control_processor i_pfs_control_processor (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .link(link), .i_data(din), .o_data(out_bit),
      .o_result(result));
   pfs_sequencer #(.INTERLEAVED(1'b0)) i_pfs_sequencer (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .link(link), .i_feature_present(present),
      .i_main_rom_data(main_word), .i_feat_rom_data({OP_STORE, pc[7:0]}),
      .o_rom_addr(rom_addr), .o_main_rom_en(main_en),
      .o_feat_rom_en(feat_en), .o_in_select(in_sel),
      .o_out_select(out_sel), .o_pc(pc));
   pfs_link_chk i_pfs_link_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .jump_pulse(link.jump_pulse), .return_pulse(link.return_pulse),
      .nop0_pulse(link.nop0_pulse), .nopf_pulse(link.nopf_pulse),
      .phase(link.phase), .opcode(link.opcode));
   // ==========================================================
   // Tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic t_reset(input logic card);
      @(posedge i_clk) #1;
      present = card;
      i_sys_rst = 1'b1;
      repeat (2) @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      {s_jump, s_ret, s_call, s_nop, s_wr} = {n_jump, n_ret, n_call, n_nop, n_wr};
   endtask
   task automatic t_flow();
      t_reset(1'b0);
      repeat (4) @(posedge i_clk);
      #1;
      check(pc, 12'h030);
      check(out_sel, 16'h0002);
      check(in_sel, 16'h0000);
      @(posedge i_clk) #1;
      @(posedge i_clk) #1;
      check(pc, 12'h003);
      check(in_sel, 16'h0001);
      repeat (34) @(posedge i_clk);
      #1;
      check(n_jump - s_jump, 1);
      check(n_call - s_call, 1);
      check(n_ret - s_ret, 1);
      check(n_wr - s_wr, 1);
      check(pc, 12'h060);
      check(n_nop > s_nop, 1);
   endtask
   task automatic t_noskip();
      t_reset(1'b0);
      din = 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      check(pc, 12'h0F0);
      check(result, 1'b1);
      @(posedge i_clk) #1;
      check(out_bit, 1'b1);
      din = 1'b0;
   endtask
   task automatic t_window(input logic card);
      t_reset(card);
      k = 0;
      while (pc !== 12'h800 && k < 3000) begin
         @(posedge i_clk) #1;
         k++;
      end
      check(pc, 12'h800);
      s_wr = n_wr;
      check({feat_en, main_en}, 2'b10);
      for (int i = 0; i < 256; i++) begin
         check(pc, 12'h800 + i);
         check(rom_addr, 12'h800 + i);
         @(posedge i_clk) #1;
      end
      check({feat_en, main_en}, 2'b01);
      check(n_wr != s_wr, card);
   endtask
   task automatic t_wrap();
      k = 0;
      while (pc !== 12'hFFF && k < 2000) begin
         @(posedge i_clk) #1;
         k++;
      end
      check(pc, 12'hFFF);
      @(posedge i_clk) #1;
      check(pc, 12'h000);
   endtask
   task automatic wrap_up();
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   initial begin
      t_flow();
      t_noskip();
      t_window(1'b0);
      t_wrap();
      t_window(1'b1);
      wrap_up();
   end
endmodule
